// ==== src/mft_defs.vh ====
/*
  Constants for the multifunction timer channel: register map, mode codes,
  control bit positions and reset values.
  Assumes inclusion by bare name from the timer design file.
*/
`ifndef MFT_DEFS_VH
`define MFT_DEFS_VH

// Register indices on the plain register port
`define REG_COUNTER    3'h0
`define REG_RELOAD     3'h1
`define REG_CONTROL    3'h2
`define REG_STATUS     3'h3
`define ADDR_W         3

// Mode field codes
`define MODE_TIMER     2'h0
`define MODE_EVENT     2'h1
`define MODE_ONESHOT   2'h2
`define MODE_PWM       2'h3

// Control register bit positions
`define CTL_START      0
`define CTL_MODE_LO    1
`define CTL_MODE_HI    2
`define CTL_FREERUN    3
`define CTL_UP         4
`define CTL_TRIG       5

// Status register bit positions
`define STS_IRQ        0
`define STS_OUT        1
`define STS_RUN        2

// Values
`define ALL_ONES       16'hffff
`define ALL_ZEROS      16'h0000
`define CTL_RESET      6'h00

`endif

// ==== src/multifunction_timer_unit.v ====
/*
  Multifunction timer channel: timer, event counter, one-shot and pulse-width
  modulation modes with a 16-bit counter and reload register.
  Assumes a single 200 MHz clock, an asynchronous active-low reset, a plain
  register port with read data one cycle after the read strobe, and an
  external count pulse pin that is asynchronous to the clock.
*/
// Design decisions made here: strobed register access and the address map.
// Contract
// - In timer mode a counter read returns the live count, and all ones when it meets the reload instant.
// - In event mode a read at the reload instant returns all ones after underflow and all zeros after overflow.
// - A counter write while halted is what a read returns until counting starts.
// - In one-shot mode clearing start while the output is high stops, reloads, drives the output low and raises the request.
// - The request bit is set when one-shot mode is entered after reset or from timer or event mode.
// - The request bit is set when PWM mode is entered after reset or from timer or event mode.
// - In PWM mode clearing start stops the counter and, if the output is high, drives it low and sets the request.
// - In PWM mode clearing start while the output is low leaves it low and does not set the request.
`timescale 1ns/1ps
`include "mft_defs.vh"

module multifunction_timer_unit #(
  parameter CNT_W = 16
) (
  input  wire               mclk_in,
  input  wire               rst_n_in,
  input  wire [`ADDR_W-1:0] addr_in,
  input  wire [CNT_W-1:0]   wdata_in,
  input  wire               wr_in,
  input  wire               rd_in,
  input  wire               event_pin_in,
  output reg  [CNT_W-1:0]   rdata_out,
  output reg                timer_output_pin_out,
  output reg                interrupt_request_bit_out
);

  // Counter and its reload value, both software visible
  reg [CNT_W-1:0] multifunction_counter_register;
  reg [CNT_W-1:0] reload;

  // Control fields as last written; start is also cleared by a one-shot end
  reg             start;
  reg [1:0]       mode;
  reg             freerun;
  reg             count_up;
  reg             trig;

  // Remembers whether control was ever written, for the entry request
  reg             mode_touched;

  // Output phase and the one-cycle reload marker behind the wrap readback
  reg             pwm_phase;
  reg             reload_now;
  reg             reload_ovf;

  // Two-flop synchroniser, then an edge detector on the second stage only
  // Its idle level matches the pin's, so reset leaves no false edge
  reg ev_s1;
  reg ev_s2;
  reg ev_d;
  wire ev_edge = ev_s2 & ~ev_d;

  // Decoded accesses and events
  wire wr_cnt  = wr_in && (addr_in == `REG_COUNTER);
  wire wr_rel  = wr_in && (addr_in == `REG_RELOAD);
  wire wr_ctl  = wr_in && (addr_in == `REG_CONTROL);
  wire wr_sts  = wr_in && (addr_in == `REG_STATUS);
  wire [1:0] new_mode  = wdata_in[`CTL_MODE_HI:`CTL_MODE_LO];
  wire       new_start = wdata_in[`CTL_START];
  wire       stop_req  = wr_ctl && start && !new_start;
  wire       cnt_zero  = (multifunction_counter_register == `ALL_ZEROS);
  wire       cnt_full  = (multifunction_counter_register == `ALL_ONES);
  wire       is_event  = (mode == `MODE_EVENT);
  wire       tick      = is_event ? ev_edge : 1'b1;
  wire       up_dir    = is_event && count_up;
  // Wrap point: all zeros counting down, all ones counting up
  wire       wrap      = up_dir ? cnt_full : cnt_zero;
  wire       one_shot_live = (mode == `MODE_ONESHOT) && start && timer_output_pin_out;

  // Spurious request when entering one-shot or PWM from reset, timer or event
  // Software must clear it before relying on the request
  wire enter_irq = wr_ctl && new_mode[1] && (!mode_touched || !mode[1]);
  // Stop in one-shot or in PWM while the output is high
  wire stop_irq  = stop_req && ((one_shot_live) ||
                                ((mode == `MODE_PWM) && timer_output_pin_out));
  // Wrap of a running count
  wire wrap_irq  = start && tick && wrap && !stop_req && !wr_cnt;

  // Synchroniser for the external count pulse
  // Only the second stage feeds logic; the first may still be settling
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ev_s1 <= 1'b0;
      ev_s2 <= 1'b0;
      ev_d  <= 1'b0;
    end else begin
      ev_s1 <= event_pin_in;
      ev_s2 <= ev_s1;
      ev_d  <= ev_s2;
    end
  end

  // Control and reload registers
  // Mode and options change only on a full control write; trig is stored, not used
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reload       <= `ALL_ZEROS;
      start        <= 1'b0;
      mode         <= `MODE_TIMER;
      freerun      <= 1'b0;
      count_up     <= 1'b0;
      trig         <= 1'b0;
      mode_touched <= 1'b0;
    end else begin
      if (wr_rel)
        reload <= wdata_in;
      if (wr_ctl) begin
        start        <= new_start;
        mode         <= new_mode;
        freerun      <= wdata_in[`CTL_FREERUN];
        count_up     <= wdata_in[`CTL_UP];
        trig         <= wdata_in[`CTL_TRIG];
        mode_touched <= 1'b1;
      end else if (start && tick && wrap && (mode == `MODE_ONESHOT)) begin
        start <= 1'b0;  // One-shot ends itself at the wrap
      end
    end
  end

  // Counter, output pin and reload-instant marker
  // A stop outranks a same-cycle counter write, so clearing start always takes effect
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      multifunction_counter_register <= `ALL_ZEROS;
      timer_output_pin_out           <= 1'b0;
      pwm_phase                      <= 1'b0;
      reload_now                     <= 1'b0;
      reload_ovf                     <= 1'b0;
    end else begin
      reload_now <= 1'b0;
      if (stop_req) begin
        if (mode == `MODE_ONESHOT && one_shot_live)
          multifunction_counter_register <= reload;
        if (mode[1])
          timer_output_pin_out <= 1'b0;
        pwm_phase <= 1'b0;
      end else if (wr_cnt) begin
        // A halted write is what the next read returns
        multifunction_counter_register <= wdata_in;
      end else if (wr_ctl && new_start && !start && mode[1] == 1'b1 && new_mode[1]) begin
        // Start of a one-shot or PWM run loads the reload value only if the halted mode was already one-shot or PWM
        multifunction_counter_register <= reload;
        timer_output_pin_out           <= 1'b1;  // Output rises as the pulse starts
        pwm_phase                      <= 1'b1;
      end else if (start && tick) begin
        if (!wrap) begin
          // Live count between reloads
          if (up_dir)
            multifunction_counter_register <= multifunction_counter_register + 16'h0001;
          else
            multifunction_counter_register <= multifunction_counter_register - 16'h0001;
        end else begin
          // Mark the reload instant for one cycle of wrap readback
          reload_now <= 1'b1;
          reload_ovf <= up_dir;
          if (is_event && freerun)
            multifunction_counter_register <= up_dir ? `ALL_ZEROS : `ALL_ONES;
          else
            multifunction_counter_register <= reload;
          if (mode == `MODE_ONESHOT)
            timer_output_pin_out <= 1'b0;
          else if (mode == `MODE_PWM) begin
            // Alternate high and low periods from the same reload
            pwm_phase            <= ~pwm_phase;
            timer_output_pin_out <= ~pwm_phase;
          end
        end
      end
    end
  end

  // Request bit; a hardware set wins over a software clear
  // Only writing zero clears it, so writing back a read of ones is harmless
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      interrupt_request_bit_out <= 1'b0;
    else if (enter_irq || stop_irq || wrap_irq)
      interrupt_request_bit_out <= 1'b1;
    else if (wr_sts && !wdata_in[`STS_IRQ])
      interrupt_request_bit_out <= 1'b0;
  end

  // Read port; a read at the reload instant sees the wrap value, not the reload
  // Limitation: after a one-shot end the marker is ignored, as start is already low
  // Unmapped indices and idle cycles read as zero
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      rdata_out <= `ALL_ZEROS;
    else if (rd_in) begin
      case (addr_in)
        `REG_COUNTER:
          if (reload_now && start)
            rdata_out <= (is_event && reload_ovf) ? `ALL_ZEROS : `ALL_ONES;
          else
            rdata_out <= multifunction_counter_register;
        `REG_RELOAD:
          rdata_out <= reload;
        `REG_CONTROL:
          rdata_out <= {10'h000, trig, count_up, freerun, mode, start};
        `REG_STATUS:
          rdata_out <= {13'h0000, start, timer_output_pin_out, interrupt_request_bit_out};
        default:
          rdata_out <= `ALL_ZEROS;
      endcase
    end else
      rdata_out <= `ALL_ZEROS;
  end

endmodule

// ==== verif/mft_monitor.sv ====
/* Port checker for the timer channel.
   Assumes the header constants and binding from the bench. */
`timescale 1ns/1ps
`include "mft_defs.vh"
module mft_monitor #(parameter CNT_W = 16) (
  input wire logic               mclk_in,
  input wire logic               rst_n_in,
  input wire logic [`ADDR_W-1:0] addr_in,
  input wire logic [CNT_W-1:0]   wdata_in,
  input wire logic               wr_in,
  input wire logic               rd_in,
  input wire logic               event_pin_in,
  input wire logic [CNT_W-1:0]   rdata_out,
  input wire logic               timer_output_pin_out,
  input wire logic               interrupt_request_bit_out
);
  logic [5:0]       ctl;
  logic [CNT_W-1:0] wlast;
  logic             fresh;
  wire c_w = wr_in && addr_in == `REG_CONTROL;
  wire c_rd = rd_in && addr_in == `REG_COUNTER;
  // Shadow of control and last counter write; start may be stale after a one-shot end
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl <= 6'h00;
      wlast <= '0;
      fresh <= 1'b0;
    end else begin
      if (c_w) ctl <= wdata_in[5:0];
      if (wr_in && addr_in == `REG_COUNTER) wlast <= wdata_in;
      fresh <= (wr_in && addr_in == `REG_COUNTER) || (fresh && !c_w);
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  a_halted_read: assert property (c_rd && !ctl[0] && fresh |=> rdata_out == wlast)
    else $error("halted counter readback differs");
  a_halted_steady: assert property (c_rd && !ctl[0] ##1 c_rd |=> $stable(rdata_out))
    else $error("halted counter moved");
  a_oneshot_flag: assert property (c_w && wdata_in[2:1] == `MODE_ONESHOT && ctl[2:1] < 2'h2
    |-> ##[1:2] interrupt_request_bit_out) else $error("no request on one-shot entry");
  a_pwm_flag: assert property (c_w && wdata_in[2:1] == `MODE_PWM && ctl[2:1] < 2'h2
    |-> ##[1:2] interrupt_request_bit_out) else $error("no request on pwm entry");
  a_oneshot_stop: assert property (c_w && ctl[2:0] == 3'h5 && wdata_in[2:0] == 3'h4 && timer_output_pin_out
    |-> ##[1:2] (!timer_output_pin_out && interrupt_request_bit_out)) else $error("one-shot stop wrong");
  a_pwm_stop_high: assert property (c_w && ctl[2:0] == 3'h7 && wdata_in[2:0] == 3'h6 && timer_output_pin_out
    |-> ##[1:2] (!timer_output_pin_out && interrupt_request_bit_out)) else $error("pwm stop high wrong");
  a_pwm_stop_low: assert property (c_w && ctl[2:0] == 3'h7 && wdata_in[2:0] == 3'h6 && !timer_output_pin_out
    && !interrupt_request_bit_out |=> (!timer_output_pin_out && !interrupt_request_bit_out) [*2])
    else $error("pwm stop low wrong");
  a_timer_live: assert property (ctl[2:0] == 3'h1 && c_rd ##1 c_rd |=> $past(rdata_out) == 16'hffff
    || rdata_out == ($past(rdata_out) == 16'h0000 ? 16'hffff : $past(rdata_out) - 16'h0001))
    else $error("timer live read wrong");
  c_event_start: cover property (c_w && wdata_in[2:0] == 3'h3);
  c_reload_ones: cover property (c_rd ##1 rdata_out == 16'hffff);
  c_reload_zero: cover property (c_rd && ctl[2:1] == `MODE_EVENT ##1 rdata_out == 16'h0000);
endmodule

// ==== verif/event_source.sv ====
/* Far-side model: count pulse source and output pin load.
   Assumes the bench calls pulses() from its main sequence. */
`timescale 1ns/1ps
module event_source (
  input  wire logic mclk_in,
  input  wire logic load_in,
  output logic      event_out
);
  initial event_out = 1'b0;
  // Rising edges seen by the output pin load, counted for the bench
  int   load_rises = 0;
  logic load_q = 1'b0;
  always @(posedge mclk_in) begin
    load_q <= load_in;
    if (load_in && !load_q)
      load_rises <= load_rises + 1;
  end
  // Four clocks high and at least four low so the two-flop sync never misses an edge
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge mclk_in) event_out <= 1'b1;
      repeat (4) @(posedge mclk_in);
      event_out <= 1'b0;
      repeat (4) @(posedge mclk_in);
    end
  endtask
endmodule

// ==== verif/tb.sv ====
/* Self-checking bench for the timer channel over its register port.
   Assumes the timer design, its header, the checker and the pulse source. */
`timescale 1ns/1ps
`include "mft_defs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb;
  logic        mclk_in, rst_n_in, wr_in, rd_in, ev, pin, irq, s1, s0;
  logic [2:0]  addr_in;
  logic [15:0] wdata_in, rdata_out, v;
  int          num_errors = 0;
  int          cmp_count = 0;
  multifunction_timer_unit #(.CNT_W(16)) multifunction_timer_unit_inst (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .event_pin_in(ev), .rdata_out(rdata_out), .timer_output_pin_out(pin), .interrupt_request_bit_out(irq));
  event_source event_source_inst (.mclk_in(mclk_in), .load_in(pin), .event_out(ev));
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  // Write, then let any registered effect land before looking
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk_in) {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
    @(posedge mclk_in) wr_in <= 1'b0;
    @(posedge mclk_in) #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge mclk_in) {rd_in, addr_in} <= {1'b1, a};
    @(posedge mclk_in) rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  // Back-to-back counter reads; notes whether all ones or all zeros showed up
  task automatic burst(input int n);
    s1 = 1'b0;
    s0 = 1'b0;
    @(posedge mclk_in) {rd_in, addr_in} <= {1'b1, `REG_COUNTER};
    repeat (n) begin
      @(posedge mclk_in) #1;
      s1 |= rdata_out === 16'hffff;
      s0 |= rdata_out === 16'h0000;
    end
    @(posedge mclk_in) rd_in <= 1'b0;
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    {rst_n_in, wr_in, rd_in, addr_in, wdata_in} = '0;
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    wr(`REG_COUNTER, 16'h1234);
    rd(`REG_COUNTER, v); `CHK(v, 16'h1234)
    burst(3); `CHK(s1 | s0, 1'b0)
    rd(3'h5, v); `CHK(v, 16'h0000)
    $display("register test done");
    wr(`REG_COUNTER, 16'h0003);
    wr(`REG_RELOAD, 16'h0005);
    wr(`REG_CONTROL, 16'h0001);
    burst(16); `CHK(s1, 1'b1)
    wr(`REG_RELOAD, 16'h0040);
    wr(`REG_CONTROL, 16'h0000);
    wr(`REG_STATUS, 16'h0000); `CHK(irq, 1'b0)
    wr(`REG_CONTROL, 16'h0004); `CHK(irq, 1'b1)
    wr(`REG_STATUS, 16'h0000); `CHK(irq, 1'b0)
    wr(`REG_CONTROL, 16'h0005); `CHK(pin, 1'b1)
    wr(`REG_CONTROL, 16'h0004); `CHK({pin, irq}, 2'b01)
    rd(`REG_COUNTER, v); `CHK(v, 16'h0040)
    wr(`REG_CONTROL, 16'h0000);
    wr(`REG_STATUS, 16'h0000);
    wr(`REG_CONTROL, 16'h0006); `CHK(irq, 1'b1)
    wr(`REG_STATUS, 16'h0000);
    wr(`REG_CONTROL, 16'h0007); `CHK(pin, 1'b1)
    wr(`REG_CONTROL, 16'h0006); `CHK({pin, irq}, 2'b01)
    wr(`REG_STATUS, 16'h0000);
    wr(`REG_CONTROL, 16'h0007);
    for (int i = 0; i < 200 && pin !== 1'b0; i++) @(posedge mclk_in) #1;
    `CHK(pin, 1'b0)
    wr(`REG_STATUS, 16'h0000);
    wr(`REG_CONTROL, 16'h0006); `CHK({pin, irq}, 2'b00)
    $display("timer tests done");
    wr(`REG_CONTROL, 16'h000b);
    wr(`REG_COUNTER, 16'h0001);
    event_source_inst.pulses(3);
    wr(`REG_CONTROL, 16'h000a);
    rd(`REG_COUNTER, v); `CHK(v, 16'hfffe)
    wr(`REG_RELOAD, 16'h0007);
    wr(`REG_COUNTER, 16'h0001);
    wr(`REG_CONTROL, 16'h0003);
    fork event_source_inst.pulses(2); burst(30); join
    `CHK(s1, 1'b1)
    wr(`REG_CONTROL, 16'h0012);
    wr(`REG_COUNTER, 16'hfffe);
    wr(`REG_CONTROL, 16'h0013);
    fork event_source_inst.pulses(2); burst(30); join
    `CHK(s0, 1'b1)
    `CHK(event_source_inst.load_rises, 3)
    $display("event tests done");
    final_report;
  end
endmodule
bind multifunction_timer_unit mft_monitor #(.CNT_W(CNT_W)) mft_monitor_inst (.mclk_in(mclk_in),
  .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .event_pin_in(event_pin_in), .rdata_out(rdata_out), .timer_output_pin_out(timer_output_pin_out),
  .interrupt_request_bit_out(interrupt_request_bit_out));
